// [adc_seq_pkg.sv]
// Shared constants for the converter sequence and trigger control
package adc_seq_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] FIRST_SEQ_OFFSET = 8'h08;
    localparam logic [7:0] SECOND_SEQ_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] MASK_OFFSET = 8'h14;
    localparam logic [7:0] RESULT_BASE_OFFSET = 8'h20;
    localparam logic [7:0] RESULT_LAST_OFFSET = 8'h4C;
    // Control register fields
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_DIV_W = 8;
    localparam int CTRL_LOW_POWER_BIT = 10;
    // Sequence control fields
    localparam int SEQ_MASK_LSB = 0;
    localparam int SEQ_MASK_W = 12;
    localparam int SEQ_EXTRA_LSB = 12;
    localparam int SEQ_EXTRA_W = 3;
    localparam int SEQ_SRC_LSB = 16;
    localparam int SEQ_SRC_W = 4;
    localparam int SEQ_POL_BIT = 20;
    localparam int SEQ_STEP_BIT = 21;
    localparam int SEQ_START_BIT = 26;
    localparam int SEQ_MODE_BIT = 30;
    localparam int SEQ_ENABLE_BIT = 31;
    // Status bits: sequence done events, conversion done and overrun
    localparam int STAT_FIRST_DONE = 0;
    localparam int STAT_SECOND_DONE = 1;
    localparam int STAT_CONV_DONE = 2;
    localparam int STAT_OVERRUN = 3;
    localparam int STAT_W = 4;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // Hardware launch source codes
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_PIN0 = 4'h1;
    localparam logic [3:0] SRC_PIN1 = 4'h2;
    localparam logic [3:0] SRC_TIMER = 4'h5;
    localparam logic [3:0] SRC_COMP = 4'h6;
    localparam logic [3:0] SRC_PATTERN = 4'h7;
    localparam logic [3:0] SRC_CORE = 4'h8;
    // Conversion timing in conversion clocks (6.5 sample, 31 total)
    localparam int SAMPLE_HALF_CLOCKS = 13;
    localparam int CONV_CLOCKS = 31;
    localparam int SAR_CLOCKS = CONV_CLOCKS - (SAMPLE_HALF_CLOCKS + 1) / 2;
    localparam int MAX_CONV_CLOCK_MHZ = 15;
    localparam int SYS_CLOCK_MHZ = 200;
    localparam int MIN_DIVISOR = (SYS_CLOCK_MHZ + MAX_CONV_CLOCK_MHZ - 1) / MAX_CONV_CLOCK_MHZ;
    localparam int WAKE_CLOCKS = 2;
    localparam logic [11:0] FULL_SCALE = 12'hFFF;
endpackage

// [adc_conv_engine.sv]
// Conversion timing engine: divided clock, sampling and result capture
module adc_conv_engine #(
    parameter int RES_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Control
    input wire logic [7:0] divisor_i,
    input wire logic [2:0] extra_i,
    input wire logic launch_i,
    // Analog result from the successive-approximation core
    input wire logic [RES_W-1:0] sar_code_i,
    // Status
    output logic busy_o,
    output logic done_o,
    output logic [RES_W-1:0] result_o
);
    logic [7:0] div_cnt_reg, div_cnt_next;
    logic [5:0] clk_cnt_reg, clk_cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [RES_W-1:0] result_reg, result_next;
    logic [5:0] total;
    logic tick;

    // Effective divide never faster than the converter's clock ceiling
    function automatic logic [7:0] eff_div(input logic [7:0] d);
        return (d < 8'(adc_seq_pkg::MIN_DIVISOR - 1)) ? 8'(adc_seq_pkg::MIN_DIVISOR - 1) : d;
    endfunction

    assign tick = (div_cnt_reg == eff_div(divisor_i));
    // Default 31 clocks, lengthened by extra sample clocks
    assign total = 6'(adc_seq_pkg::CONV_CLOCKS) + {3'h0, extra_i};

    always_comb begin
        div_cnt_next = div_cnt_reg;
        clk_cnt_next = clk_cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        result_next = result_reg;
        if (busy_reg) begin
            div_cnt_next = tick ? 8'h00 : div_cnt_reg + 8'h01;
            if (tick) begin
                clk_cnt_next = clk_cnt_reg + 6'h01;
                if (clk_cnt_next == total) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    // Core output already clamps to 0..full scale
                    result_next = sar_code_i;
                end
            end
        end else if (launch_i) begin
            busy_next = 1'b1;
            div_cnt_next = 8'h00;
            clk_cnt_next = 6'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_cnt_reg <= 8'h00;
            clk_cnt_reg <= 6'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            result_reg <= '0;
        end else if (ce_i) begin
            div_cnt_reg <= div_cnt_next;
            clk_cnt_reg <= clk_cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            result_reg <= result_next;
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign result_o = result_reg;
endmodule

// [adc_sequence_trigger_control.sv]
// Converter sequence and trigger control with Wishbone register port
// How it works
// - Each start write converts while the sequence is enabled.
// - Polarity, enable and start take effect together in one write.
// - Result is unsigned 12-bit, clamped to zero and full scale.
// - Channel mask has one bit per channel.
// - Two sequences, each with its own hardware source field.
// - Source codes 1,2,5,6,7,8 select the six hardware triggers.
// - Per-trigger step converts the next selected channel per trigger edge.
// - Mode one raises the done interrupt only at sequence end.
// - Per-step over four channels interrupts after the fourth conversion.
// - Low-power mode powers down when idle, wakes on any trigger.
// - Four separate interrupt outputs.
// - Divisor zero is raised to a divide by 14, about 14.3 MHz, under 461 thousand samples per second.
// - Each channel's result lands in its own result word.
// - Sequence repeats on each trigger until disabled.
// - Sampling 6.5 clocks, 31 per conversion, plus extra sample clocks.
// - Programmable divider, conversion clock at most 15 MHz.
module adc_sequence_trigger_control #(
    parameter int CHANNELS = 12,
    parameter int RES_W = 12
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Hardware trigger sources
    input wire logic pin_event0_request_i,
    input wire logic pin_event1_request_i,
    input wire logic timer_match3_request_i,
    input wire logic comparator_out_request_i,
    input wire logic pattern_match_request_i,
    input wire logic core_event_request_i,
    // Analog core
    input wire logic [RES_W-1:0] sar_code_i,
    output logic [3:0] channel_select_o,
    output logic converter_power_o,
    // Interrupts
    output logic first_sequence_done_irq_o,
    output logic second_sequence_done_irq_o,
    output logic conversion_done_irq_o,
    output logic overrun_irq_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAKE = 2'b01,
        ST_CONV = 2'b10
    } state_t;

    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] seq_reg [2];
    logic [31:0] seq_next [2];
    logic [adc_seq_pkg::STAT_W-1:0] status_reg, status_next;
    logic [adc_seq_pkg::STAT_W-1:0] mask_reg, mask_next;
    logic [RES_W-1:0] result_reg [CHANNELS];
    logic [RES_W-1:0] result_next [CHANNELS];
    logic [CHANNELS-1:0] remain_reg [2];
    logic [CHANNELS-1:0] remain_next [2];
    logic [1:0] pend_reg, pend_next;
    logic active_reg, active_next;
    logic [3:0] chan_reg, chan_next;
    logic [1:0] wake_reg, wake_next;
    logic [1:0] trig_prev_reg, trig_prev_next;
    state_t state_reg, state_next;
    logic ack_reg;
    logic [5:0] sync1_reg, sync2_reg;
    logic [31:0] rd_data;
    logic wr, launch, eng_busy, eng_done;
    logic [1:0] start_wr, trig_level, trig_edge;
    logic [RES_W-1:0] eng_result;
    logic [adc_seq_pkg::STAT_W-1:0] events;

    // Byte-lane merge for a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    // Selected source level
    function automatic logic src_level(input logic [3:0] src, input logic [5:0] s);
        case (src)
            adc_seq_pkg::SRC_PIN0: return s[0];
            adc_seq_pkg::SRC_PIN1: return s[1];
            adc_seq_pkg::SRC_TIMER: return s[2];
            adc_seq_pkg::SRC_COMP: return s[3];
            adc_seq_pkg::SRC_PATTERN: return s[4];
            adc_seq_pkg::SRC_CORE: return s[5];
            default: return 1'b0;
        endcase
    endfunction

    // Lowest set channel of a mask
    function automatic logic [3:0] first_chan(input logic [CHANNELS-1:0] m);
        logic [3:0] c;
        c = 4'h0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (m[i]) c = 4'(i);
        end
        return c;
    endfunction

    // Two-stage synchroniser for the external trigger sources
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else if (ce_i) begin
            sync1_reg <= {core_event_request_i, pattern_match_request_i,
                          comparator_out_request_i, timer_match3_request_i,
                          pin_event1_request_i, pin_event0_request_i};
            sync2_reg <= sync1_reg;
        end
    end

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

    // Each sequence decodes its own source and edge
    always_comb begin
        for (int q = 0; q < 2; q++) begin
            // A clear polarity bit inverts the level so a rising edge is always the active one
            trig_level[q] = src_level(seq_reg[q][adc_seq_pkg::SEQ_SRC_LSB +: adc_seq_pkg::SEQ_SRC_W],
                                      sync2_reg) ^ !seq_reg[q][adc_seq_pkg::SEQ_POL_BIT];
            trig_edge[q] = trig_level[q] && !trig_prev_reg[q]
                           && seq_reg[q][adc_seq_pkg::SEQ_ENABLE_BIT];
            start_wr[q] = wr && wb_sel_i[3]
                          && wb_adr_i == (q == 0 ? adc_seq_pkg::FIRST_SEQ_OFFSET
                                                 : adc_seq_pkg::SECOND_SEQ_OFFSET)
                          && wb_dat_i[adc_seq_pkg::SEQ_START_BIT]
                          && wb_dat_i[adc_seq_pkg::SEQ_ENABLE_BIT];
        end
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        seq_next = seq_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        result_next = result_reg;
        remain_next = remain_reg;
        pend_next = pend_reg;
        active_next = active_reg;
        chan_next = chan_reg;
        wake_next = wake_reg;
        state_next = state_reg;
        trig_prev_next = trig_level;
        events = '0;
        launch = 1'b0;
        if (wr) begin
            // Selected byte lanes applied at once to control and sequence words; mask written whole
            case (wb_adr_i)
                adc_seq_pkg::CTRL_OFFSET: ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i);
                adc_seq_pkg::FIRST_SEQ_OFFSET: seq_next[0] = merge(seq_reg[0], wb_dat_i, wb_sel_i);
                adc_seq_pkg::SECOND_SEQ_OFFSET: seq_next[1] = merge(seq_reg[1], wb_dat_i, wb_sel_i);
                adc_seq_pkg::MASK_OFFSET: mask_next = wb_dat_i[adc_seq_pkg::STAT_W-1:0];
                default: ;
            endcase
        end
        for (int q = 0; q < 2; q++) begin
            // Start is self-clearing
            seq_next[q][adc_seq_pkg::SEQ_START_BIT] = 1'b0;
            if (!seq_next[q][adc_seq_pkg::SEQ_ENABLE_BIT]) begin
                pend_next[q] = 1'b0;
            end else if (trig_edge[q] || start_wr[q]) begin
                if (pend_reg[q]) events[adc_seq_pkg::STAT_OVERRUN] = 1'b1;
                pend_next[q] = 1'b1;
            end
        end
        case (state_reg)
            ST_IDLE: begin
                if (pend_reg != 2'b00) begin
                    active_next = !pend_reg[0];
                    // Wake from low power on any trigger
                    wake_next = 2'(adc_seq_pkg::WAKE_CLOCKS);
                    state_next = ctrl_reg[adc_seq_pkg::CTRL_LOW_POWER_BIT] ? ST_WAKE : ST_CONV;
                    if (remain_reg[!pend_reg[0]] == '0) begin
                        remain_next[!pend_reg[0]] =
                            seq_reg[!pend_reg[0]][adc_seq_pkg::SEQ_MASK_LSB +: CHANNELS];
                    end
                end
            end
            ST_WAKE: begin
                wake_next = wake_reg - 2'h1;
                if (wake_reg == 2'h1) state_next = ST_CONV;
            end
            ST_CONV: begin
                if (!eng_busy && !eng_done) begin
                    chan_next = first_chan(remain_reg[active_reg]);
                    launch = remain_reg[active_reg] != '0;
                    if (!launch) begin
                        state_next = ST_IDLE;
                        pend_next[active_reg] = 1'b0;
                    end
                end
                if (eng_done) begin
                    result_next[chan_reg] = eng_result;
                    remain_next[active_reg][chan_reg] = 1'b0;
                    if (!seq_reg[active_reg][adc_seq_pkg::SEQ_MODE_BIT]) begin
                        events[adc_seq_pkg::STAT_CONV_DONE] = 1'b1;
                    end
                    if (remain_next[active_reg] == '0) begin
                        // Whole sequence done
                        if (seq_reg[active_reg][adc_seq_pkg::SEQ_MODE_BIT]) begin
                            events[active_reg] = 1'b1;
                        end
                        pend_next[active_reg] = 1'b0;
                        state_next = ST_IDLE;
                    end else if (seq_reg[active_reg][adc_seq_pkg::SEQ_STEP_BIT]) begin
                        // One channel per trigger edge
                        pend_next[active_reg] = pend_next[active_reg] && pend_reg != pend_next;
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Write-one-to-clear; a simultaneous event wins
        if (wr && wb_adr_i == adc_seq_pkg::STATUS_OFFSET) begin
            status_next = status_reg & ~wb_dat_i[adc_seq_pkg::STAT_W-1:0];
        end
        status_next = status_next | events;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg <= adc_seq_pkg::RESET_VALUE;
            seq_reg <= '{default: adc_seq_pkg::RESET_VALUE};
            mask_reg <= '0;
            status_reg <= '0;
            result_reg <= '{default: '0};
            remain_reg <= '{default: '0};
            pend_reg <= 2'b00;
            active_reg <= 1'b0;
            chan_reg <= 4'h0;
            wake_reg <= 2'h0;
            trig_prev_reg <= 2'b00;
            state_reg <= ST_IDLE;
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ctrl_reg <= ctrl_next;
            seq_reg <= seq_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            result_reg <= result_next;
            remain_reg <= remain_next;
            pend_reg <= pend_next;
            active_reg <= active_next;
            chan_reg <= chan_next;
            wake_reg <= wake_next;
            trig_prev_reg <= trig_prev_next;
            state_reg <= state_next;
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            adc_seq_pkg::CTRL_OFFSET: rd_data = ctrl_reg;
            adc_seq_pkg::FIRST_SEQ_OFFSET: rd_data = seq_reg[0];
            adc_seq_pkg::SECOND_SEQ_OFFSET: rd_data = seq_reg[1];
            adc_seq_pkg::STATUS_OFFSET: rd_data = 32'(status_reg);
            adc_seq_pkg::MASK_OFFSET: rd_data = 32'(mask_reg);
            default: begin
                if (wb_adr_i >= adc_seq_pkg::RESULT_BASE_OFFSET
                    && wb_adr_i <= adc_seq_pkg::RESULT_LAST_OFFSET && wb_adr_i[1:0] == 2'b00) begin
                    rd_data = 32'(result_reg[4'(wb_adr_i[7:2] - adc_seq_pkg::RESULT_BASE_OFFSET[7:2])]);
                end
            end
        endcase
    end

    // Read data registered so it is stable with ack
    logic [31:0] dat_reg;
    always_ff @(posedge clk_i) begin
        if (reset_i) dat_reg <= 32'h0000_0000;
        else if (ce_i) dat_reg <= rd_data;
    end

    adc_conv_engine #(
        .RES_W(RES_W)
    ) u_engine (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .divisor_i(ctrl_reg[adc_seq_pkg::CTRL_DIV_LSB +: adc_seq_pkg::CTRL_DIV_W]),
        .extra_i(seq_reg[active_reg][adc_seq_pkg::SEQ_EXTRA_LSB +: adc_seq_pkg::SEQ_EXTRA_W]),
        .launch_i(launch),
        .sar_code_i(sar_code_i),
        .busy_o(eng_busy),
        .done_o(eng_done),
        .result_o(eng_result)
    );

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign channel_select_o = chan_reg;
    // Powered unless low power is on and the sequencer is idle
    assign converter_power_o = !ctrl_reg[adc_seq_pkg::CTRL_LOW_POWER_BIT] || state_reg != ST_IDLE;
    // Four separate request lines
    assign first_sequence_done_irq_o = status_reg[adc_seq_pkg::STAT_FIRST_DONE]
                                       && mask_reg[adc_seq_pkg::STAT_FIRST_DONE];
    assign second_sequence_done_irq_o = status_reg[adc_seq_pkg::STAT_SECOND_DONE]
                                        && mask_reg[adc_seq_pkg::STAT_SECOND_DONE];
    assign conversion_done_irq_o = status_reg[adc_seq_pkg::STAT_CONV_DONE]
                                   && mask_reg[adc_seq_pkg::STAT_CONV_DONE];
    assign overrun_irq_o = status_reg[adc_seq_pkg::STAT_OVERRUN]
                           && mask_reg[adc_seq_pkg::STAT_OVERRUN];
endmodule

// [adc_seq_assertions.sv]
// Concurrent checks on the converter control ports
module adc_seq_assertions #(
    parameter int CHANNELS = 12,
    parameter int RES_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Converter and interrupts
    input wire logic [3:0] channel_select_o,
    input wire logic converter_power_o,
    input wire logic first_sequence_done_irq_o,
    input wire logic second_sequence_done_irq_o,
    input wire logic conversion_done_irq_o,
    input wire logic overrun_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence wb_read_hole;
        wb_req ##0 (!wb_we_i && wb_adr_i == 8'h04);
    endsequence
    a_ack_follows_req: assert property (wb_req |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_hole_reads_zero: assert property (wb_read_hole |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($past(reset_i) |->
        converter_power_o &&
        !(first_sequence_done_irq_o || second_sequence_done_irq_o || conversion_done_irq_o
        || overrun_irq_o)) else $error("outputs not at reset state");
    a_first_irq_sticky: assert property
        (first_sequence_done_irq_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=>
        first_sequence_done_irq_o) else $error("first done irq dropped by itself");
    a_second_irq_sticky: assert property
        (second_sequence_done_irq_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=>
        second_sequence_done_irq_o) else $error("second done irq dropped by itself");
    a_channel_in_range: assert property (channel_select_o < CHANNELS)
        else $error("channel select out of range");
endmodule

// [adc_far_side_model.sv]
// Far-side model: analog core codes and hardware trigger sources
module adc_far_side_model (
    // Clock
    input wire logic clk_i,
    // Analog core
    input wire logic [3:0] channel_select_i,
    output logic [11:0] sar_code_o,
    // Trigger levels
    output logic [5:0] trig_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial trig_o = 6'h00;
    // Channel 3 sits above the top reference, so it reads full scale
    assign sar_code_o = (channel_select_i == 4'h3) ? 12'hFFF
                        : {channel_select_i, 8'h5A};
    // Level held long enough for the two-flop synchroniser
    task automatic fire(input int k);
        @(posedge clk_i);
        trig_o[k] <= 1'b1;
        repeat (8) @(posedge clk_i);
        trig_o[k] <= 1'b0;
    endtask
endmodule

// [adc_sequence_trigger_control_tb.sv]
// Register-level testbench for the converter sequence control
module adc_sequence_trigger_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CHANNELS = 12;
    localparam int RES_W = 12;
    logic clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, converter_power_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    logic [3:0] irq_v, channel_select_o;
    logic [11:0] sar_code_i;
    logic [5:0] trig;
    int errors = 0;
    int n_checks = 0;
    const logic [3:0] src_codes [6] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
    adc_sequence_trigger_control #(.CHANNELS(CHANNELS), .RES_W(RES_W)) dut (.clk_i(clk_i),
        .reset_i(reset_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_event0_request_i(trig[0]),
        .pin_event1_request_i(trig[1]), .timer_match3_request_i(trig[2]),
        .comparator_out_request_i(trig[3]), .pattern_match_request_i(trig[4]),
        .core_event_request_i(trig[5]), .sar_code_i(sar_code_i),
        .channel_select_o(channel_select_o), .converter_power_o(converter_power_o),
        .first_sequence_done_irq_o(irq_v[0]), .second_sequence_done_irq_o(irq_v[1]),
        .conversion_done_irq_o(irq_v[2]), .overrun_irq_o(irq_v[3]));
    adc_far_side_model far (.clk_i(clk_i), .channel_select_i(channel_select_o),
        .sar_code_o(sar_code_i), .trig_o(trig));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until the edge that samples ack high
    task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            errors++;
            print_verdict();
        end
        @(posedge clk_i);
    endtask
    task automatic wait_irq(input int b);
        int n;
        for (n = 0; n < 2000 && irq_v[b] !== 1'b1; n++) @(posedge clk_i);
        if (n >= 2000) begin
            errors++;
            print_verdict();
        end
    endtask
    function automatic logic [31:0] seq_word(input logic [11:0] m, input logic [3:0] src,
        input logic step, input logic mode, input logic start);
        logic [31:0] w;
        w = {20'h0_0000, m};
        w[adc_seq_pkg::SEQ_SRC_LSB +: 4] = src;
        w[adc_seq_pkg::SEQ_POL_BIT] = 1'b1;
        w[adc_seq_pkg::SEQ_STEP_BIT] = step;
        w[adc_seq_pkg::SEQ_START_BIT] = start;
        w[adc_seq_pkg::SEQ_MODE_BIT] = mode;
        w[adc_seq_pkg::SEQ_ENABLE_BIT] = 1'b1;
        return w;
    endfunction
    function automatic logic [31:0] exp_code(input int ch);
        return (ch == 3) ? 32'h0000_0FFF : {20'h0_0000, ch[3:0], 8'h5A};
    endfunction
    task automatic read_result(input int ch);
        wb_cycle(adc_seq_pkg::RESULT_BASE_OFFSET + 8'(4 * ch), 1'b0, 32'h0000_0000);
        check({20'h0_0000, d[11:0]}, exp_code(ch));
    endtask
    initial begin
        reset_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        wb_cycle(adc_seq_pkg::CTRL_OFFSET, 1'b0, 32'h0000_0000);
        check(d, adc_seq_pkg::RESET_VALUE);
        wb_cycle(adc_seq_pkg::MASK_OFFSET, 1'b1, 32'h0000_000F);
        wb_cycle(8'h04, 1'b1, 32'hFFFF_FFFF);
        wb_cycle(8'h04, 1'b0, 32'h0000_0000);
        check(d, 32'h0000_0000);
        $display("test registers done");
        // Second pass rewrites start with source, polarity and enable kept
        repeat (2) begin
            wb_cycle(adc_seq_pkg::FIRST_SEQ_OFFSET, 1'b1,
                seq_word(12'h002, 4'h0, 0, 0, 1));
            wait_irq(adc_seq_pkg::STAT_CONV_DONE);
            read_result(1);
            wb_cycle(adc_seq_pkg::STATUS_OFFSET, 1'b1, 32'h0000_000F);
            check({28'h000_0000, irq_v}, 32'h0000_0000);
        end
        $display("test software start done");
        wb_cycle(adc_seq_pkg::FIRST_SEQ_OFFSET, 1'b1,
            seq_word(12'h00F, 4'h1, 1, 1, 0));
        for (int i = 0; i < 4; i++) begin
            far.fire(0);
            if (i < 3) begin
                repeat (700) @(negedge clk_i);
                check({31'h0, irq_v[0]}, 32'h0000_0000);
            end
        end
        wait_irq(adc_seq_pkg::STAT_FIRST_DONE);
        for (int ch = 0; ch < 4; ch++) read_result(ch);
        wb_cycle(adc_seq_pkg::STATUS_OFFSET, 1'b1, 32'h0000_000F);
        wb_cycle(adc_seq_pkg::FIRST_SEQ_OFFSET, 1'b1, 32'h0000_0000);
        $display("test per-step done");
        wb_cycle(adc_seq_pkg::CTRL_OFFSET, 1'b1, 32'h0000_0400);
        for (int k = 0; k < 6; k++) begin
            wb_cycle(adc_seq_pkg::SECOND_SEQ_OFFSET, 1'b1,
                seq_word(12'(1 << k), src_codes[k], 0, 1, 0));
            repeat (4) @(negedge clk_i);
            check({31'h0, converter_power_o}, 32'h0000_0000);
            fork
                far.fire(k);
            join_none
            wait_irq(adc_seq_pkg::STAT_SECOND_DONE);
            read_result(k);
            wb_cycle(adc_seq_pkg::STATUS_OFFSET, 1'b1, 32'h0000_000F);
        end
        $display("test trigger sources done");
        // A second edge while the first is still pending is flagged as overrun
        far.fire(5);
        far.fire(5);
        wait_irq(adc_seq_pkg::STAT_OVERRUN);
        check({28'h000_0000, irq_v}, 32'h0000_0008);
        $display("test overrun done");
        print_verdict();
    end
endmodule
bind adc_sequence_trigger_control adc_seq_assertions #(.CHANNELS(CHANNELS), .RES_W(RES_W)) chk (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .channel_select_o(channel_select_o), .converter_power_o(converter_power_o),
    .first_sequence_done_irq_o(first_sequence_done_irq_o),
    .second_sequence_done_irq_o(second_sequence_done_irq_o),
    .conversion_done_irq_o(conversion_done_irq_o), .overrun_irq_o(overrun_irq_o));
